//--- core/pnfc_top.v
// Purpose: APB controlled host for a word-wide parallel NOR flash
// Assumes: Device timing met by the counts in pnfc_map.vh at 50 MHz
// Notes:   Orders come via CTRL, progress via STATUS
// What this block does
// - Commands go out as ordinary write cycles to the command register.
// - Bypass mode programs in two writes, otherwise four.
// - Completion found by polling the toggle bit; inverted-data bit 7 flags a failed program.
// - Secure sector in erase suspend needs entry and exit sequences.
// - Special areas in program suspend need entry and exit sequences.
// - Host may command standby; device saves power until accessed.
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pnfc_map.vh"
module pnfc_top (
  input  wire        REF_CLK,
  input  wire        NRST,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  output wire [22:0] FL_ADDR,
  output wire [15:0] FL_DQ_OUT,
  output wire        FL_DQ_OE,
  input  wire [15:0] FL_DQ_IN,
  output wire        FL_CE_N,
  output wire        FL_OE_N,
  output wire        FL_WE_N,
  output reg         FL_RESET_N,
  input  wire        READY_BUSY_OUT_N,
  output reg         WRITE_PROTECT_ACCEL_IN
);
  localparam S_IDLE = 3'h0;
  localparam S_SEQ  = 3'h1;
  localparam S_READ = 3'h2;
  localparam S_POLL = 3'h3;
  localparam S_WAIT = 3'h4;
  // Cycle counts cut to the 3-bit length field of the bus cycle
  localparam [31:0] ACC_CYC  = `PNFC_T_ACC_CYC;
  localparam [31:0] PACC_CYC = `PNFC_T_PACC_CYC;
  localparam [31:0] WP_CYC   = `PNFC_T_WP_CYC;

  // ==========================================================
  // Registers
  reg [3:0]  ctrl_cmd;
  reg        go;
  reg [22:0] addr;
  reg [15:0] wdata;
  reg [15:0] rdata;
  reg        busy;
  reg        done_f;
  reg        fail_f;
  reg        bypass;
  reg        stby;
  reg        protect_err;
  reg        wp_low;
  reg [2:0]  state;
  reg [2:0]  step;
  reg [2:0]  nsteps;
  reg        poll_after;
  reg [19:0] page_tag;
  reg        page_ok;
  reg        last_dq6;
  reg        have_last;
  reg        bc_start;
  reg        bc_wr;
  reg [22:0] bc_addr;
  reg [15:0] bc_wdata;
  reg [2:0]  bc_len;
  wire [15:0] bc_rdata;
  wire        bc_done;
  wire        ready_pin = READY_BUSY_OUT_N;

  // ==========================================================
  // Command sequence word for a given step
  function [38:0] seq_word;
    input [3:0]  cmd;
    input [2:0]  idx;
    input        byp;
    input [22:0] a;
    input [15:0] d;
    reg   [38:0] u1;
    reg   [38:0] u2;
    begin
      u1 = {`PNFC_UNL_ADDR1, `PNFC_UNL_DATA1};
      u2 = {`PNFC_UNL_ADDR2, `PNFC_UNL_DATA2};
      seq_word = {a, d};
      case (cmd)
        `PNFC_CMD_PROG: begin
          if (byp) begin
            seq_word = (idx == 3'h0) ? {a, `PNFC_FD_PROG} : {a, d};
          end else begin
            case (idx)
              3'h0:    seq_word = u1;
              3'h1:    seq_word = u2;
              3'h2:    seq_word = {`PNFC_UNL_ADDR1, `PNFC_FD_PROG};
              default: seq_word = {a, d};
            endcase
          end
        end
        `PNFC_CMD_ERASE: begin
          case (idx)
            3'h0, 3'h3: seq_word = u1;
            3'h1, 3'h4: seq_word = u2;
            3'h2:       seq_word = {`PNFC_UNL_ADDR1, `PNFC_FD_ERASE1};
            default:    seq_word = {a, `PNFC_FD_ERASE2};
          endcase
        end
        `PNFC_CMD_BYP_IN: begin
          case (idx)
            3'h0:    seq_word = u1;
            3'h1:    seq_word = u2;
            default: seq_word = {`PNFC_UNL_ADDR1, `PNFC_FD_BYPASS};
          endcase
        end
        `PNFC_CMD_BYP_OUT: begin
          seq_word = (idx == 3'h0) ? {a, `PNFC_FD_BYP_X1} : {a, `PNFC_FD_BYP_X2};
        end
        `PNFC_CMD_ESUSP, `PNFC_CMD_PSUSP: seq_word = {a, `PNFC_FD_SUSP};
        `PNFC_CMD_ERES, `PNFC_CMD_PRES:   seq_word = {a, `PNFC_FD_RES};
        `PNFC_CMD_RESET: seq_word = {a, `PNFC_FD_RESET};
        // raw write for area entry and exit
        default:         seq_word = {a, d};
      endcase
    end
  endfunction

  // Steps per command; bypass program needs two writes, not four
  function [2:0] seq_len;
    input [3:0] cmd;
    input       byp;
    begin
      case (cmd)
        `PNFC_CMD_PROG:    seq_len = byp ? 3'h2 : 3'h4;
        `PNFC_CMD_ERASE:   seq_len = 3'h6;
        `PNFC_CMD_BYP_IN:  seq_len = 3'h3;
        `PNFC_CMD_BYP_OUT: seq_len = 3'h2;
        default:           seq_len = 3'h1;
      endcase
    end
  endfunction

  wire [38:0] cur_word = seq_word(ctrl_cmd, step, bypass, addr, wdata);

  // ==========================================================
  // APB slave, one wait-free access phase
  wire acc = PSEL && PENABLE;
  always @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      PRDATA  <= 32'h00000000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
      if (PSEL && !PENABLE && !PWRITE) begin
        case (PADDR)
          `PNFC_OFS_CTRL:   PRDATA <= {28'h0000000, ctrl_cmd};
          `PNFC_OFS_ADDR:   PRDATA <= {9'h000, addr};
          `PNFC_OFS_WDATA:  PRDATA <= {16'h0000, wdata};
          `PNFC_OFS_RDATA:  PRDATA <= {16'h0000, rdata};
          `PNFC_OFS_STATUS: PRDATA <= {25'h0000000, protect_err, stby, ready_pin,
                                       bypass, fail_f, done_f, busy};
          `PNFC_OFS_PROT:   PRDATA <= {31'h00000000, wp_low};
          default:          PSLVERR <= 1'b1;
        endcase
      end else if (PSEL && !PENABLE) begin
        case (PADDR)
          `PNFC_OFS_CTRL, `PNFC_OFS_ADDR, `PNFC_OFS_WDATA, `PNFC_OFS_STATUS,
          `PNFC_OFS_PROT: PSLVERR <= 1'b0;
          default:        PSLVERR <= 1'b1;
        endcase
      end
    end
  end

  wire wr_ctrl = acc && PREADY && PWRITE && (PADDR == `PNFC_OFS_CTRL);
  wire clr_st  = acc && PREADY && PWRITE && (PADDR == `PNFC_OFS_STATUS);

  // ==========================================================
  // Sequencer
  always @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl_cmd <= 4'h0;
      go <= 1'b0;
      addr <= 23'h000000;
      wdata <= 16'h0000;
      rdata <= 16'h0000;
      busy <= 1'b0;
      done_f <= 1'b0;
      fail_f <= 1'b0;
      bypass <= 1'b0;
      stby <= 1'b0;
      protect_err <= 1'b0;
      wp_low <= 1'b0;
      state <= S_IDLE;
      step <= 3'h0;
      nsteps <= 3'h0;
      poll_after <= 1'b0;
      page_tag <= 20'h00000;
      page_ok <= 1'b0;
      last_dq6 <= 1'b0;
      have_last <= 1'b0;
      bc_start <= 1'b0;
      bc_wr <= 1'b0;
      bc_addr <= 23'h000000;
      bc_wdata <= 16'h0000;
      bc_len <= 3'h0;
      FL_RESET_N <= 1'b0;
      WRITE_PROTECT_ACCEL_IN <= 1'b0;
    end else begin
      FL_RESET_N <= 1'b1;
      WRITE_PROTECT_ACCEL_IN <= !wp_low;
      bc_start <= 1'b0;
      if (acc && PREADY && PWRITE) begin
        if (PADDR == `PNFC_OFS_ADDR)  addr  <= PWDATA[22:0];
        if (PADDR == `PNFC_OFS_WDATA) wdata <= PWDATA[15:0];
        if (PADDR == `PNFC_OFS_PROT)  wp_low <= PWDATA[0];
      end
      if (clr_st) begin
        done_f <= 1'b0;
        fail_f <= 1'b0;
        protect_err <= 1'b0;
      end
      if (wr_ctrl && !busy) begin
        ctrl_cmd <= PWDATA[3:0];
        go <= 1'b1;
      end
      case (state)
        S_IDLE: begin
          if (go) begin
            go <= 1'b0;
            busy <= 1'b1;
            step <= 3'h0;
            nsteps <= seq_len(ctrl_cmd, bypass);
            poll_after <= (ctrl_cmd == `PNFC_CMD_PROG) || (ctrl_cmd == `PNFC_CMD_ERASE);
            have_last <= 1'b0;
            if (ctrl_cmd == `PNFC_CMD_READ) begin
              bc_len <= (page_ok && page_tag == addr[22:3] && !stby) ?
                        PACC_CYC[2:0] : ACC_CYC[2:0];
              bc_wr <= 1'b0;
              bc_addr <= addr;
              bc_start <= 1'b1;
              state <= S_READ;
            end else if (ctrl_cmd == `PNFC_CMD_STBY || ctrl_cmd == `PNFC_CMD_WAKE) begin
              // standby held by chip enable off
              stby <= (ctrl_cmd == `PNFC_CMD_STBY);
              page_ok <= 1'b0;
              busy <= 1'b0;
              done_f <= 1'b1;
            end else begin
              page_ok <= 1'b0;
              state <= S_SEQ;
            end
          end
        end
        S_SEQ: begin
          bc_wr <= 1'b1;
          bc_addr <= cur_word[38:16];
          bc_wdata <= cur_word[15:0];
          bc_len <= WP_CYC[2:0];
          bc_start <= 1'b1;
          state <= S_WAIT;
        end
        S_WAIT: begin
          if (bc_done) begin
            if (step + 3'h1 < nsteps) begin
              step <= step + 3'h1;
              state <= S_SEQ;
            end else if (poll_after) begin
              bc_wr <= 1'b0;
              bc_addr <= addr;
              bc_len <= ACC_CYC[2:0];
              bc_start <= 1'b1;
              state <= S_POLL;
            end else begin
              if (ctrl_cmd == `PNFC_CMD_BYP_IN)  bypass <= 1'b1;
              if (ctrl_cmd == `PNFC_CMD_BYP_OUT || ctrl_cmd == `PNFC_CMD_RESET) bypass <= 1'b0;
              busy <= 1'b0;
              done_f <= 1'b1;
              state <= S_IDLE;
            end
          end
        end
        S_READ: begin
          if (bc_done) begin
            rdata <= bc_rdata;
            page_tag <= addr[22:3];
            page_ok <= 1'b1;
            busy <= 1'b0;
            done_f <= 1'b1;
            state <= S_IDLE;
          end
        end
        S_POLL: begin
          if (bc_done) begin
            last_dq6 <= bc_rdata[6];
            have_last <= 1'b1;
            if (have_last && last_dq6 == bc_rdata[6]) begin
              fail_f <= (ctrl_cmd == `PNFC_CMD_PROG) && (bc_rdata[7] != wdata[7]);
              protect_err <= (ctrl_cmd == `PNFC_CMD_PROG) && (bc_rdata != wdata);
              busy <= 1'b0;
              done_f <= 1'b1;
              state <= S_IDLE;
            end else begin
              bc_start <= 1'b1;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  pnfc_buscyc u_cyc (
    .clk   (REF_CLK),
    .nrst  (NRST),
    .start (bc_start),
    .wr    (bc_wr),
    .addr  (bc_addr),
    .wdata (bc_wdata),
    .len   (bc_len),
    .dq_in (FL_DQ_IN),
    .a_out (FL_ADDR),
    .dq_out(FL_DQ_OUT),
    .dq_oe (FL_DQ_OE),
    .ce_n  (FL_CE_N),
    .oe_n  (FL_OE_N),
    .we_n  (FL_WE_N),
    .rdata (bc_rdata),
    .done  (bc_done)
  );
endmodule
`default_nettype wire

//--- pkg/pnfc_map.vh
// Purpose: Constants for the parallel NOR flash command controller
// Assumes: 50 MHz REF_CLK, APB slave with 32-bit data
// Notes:   Offsets are byte addresses of aligned words
`ifndef PNFC_MAP_VH
`define PNFC_MAP_VH
// ==========================================================
// Register offsets
`define PNFC_OFS_CTRL    12'h000
`define PNFC_OFS_ADDR    12'h004
`define PNFC_OFS_WDATA   12'h008
`define PNFC_OFS_RDATA   12'h00c
`define PNFC_OFS_STATUS  12'h010
`define PNFC_OFS_PROT    12'h014
// ==========================================================
// Control command field, bits 3:0 of CTRL
`define PNFC_CMD_READ    4'h1
`define PNFC_CMD_PROG    4'h2
`define PNFC_CMD_ERASE   4'h3
`define PNFC_CMD_BYP_IN  4'h4
`define PNFC_CMD_BYP_OUT 4'h5
`define PNFC_CMD_ESUSP   4'h6
`define PNFC_CMD_ERES    4'h7
`define PNFC_CMD_PSUSP   4'h8
`define PNFC_CMD_PRES    4'h9
`define PNFC_CMD_RESET   4'ha
`define PNFC_CMD_STBY    4'hb
`define PNFC_CMD_WAKE    4'hc
// ==========================================================
// Flash command sequence words
`define PNFC_UNL_ADDR1   23'h000555
`define PNFC_UNL_ADDR2   23'h0002aa
`define PNFC_UNL_DATA1   16'h00aa
`define PNFC_UNL_DATA2   16'h0055
`define PNFC_FD_PROG     16'h00a0
`define PNFC_FD_ERASE1   16'h0080
`define PNFC_FD_ERASE2   16'h0030
`define PNFC_FD_BYPASS   16'h0020
`define PNFC_FD_BYP_X1   16'h0090
`define PNFC_FD_BYP_X2   16'h0000
`define PNFC_FD_SUSP     16'h00b0
`define PNFC_FD_RES      16'h0030
`define PNFC_FD_RESET    16'h00f0
// ==========================================================
// Status bits
`define PNFC_ST_BUSY     0
`define PNFC_ST_DONE     1
`define PNFC_ST_FAIL     2
`define PNFC_ST_BYPASS   3
`define PNFC_ST_RYBY     4
`define PNFC_ST_STBY     5
`define PNFC_ST_PROTERR  6
// ==========================================================
// Bus timing, in ns and in cycles
`define PNFC_CLK_NS      20
`define PNFC_T_ACC_NS    70
`define PNFC_T_PACC_NS   30
`define PNFC_T_WP_NS     40
`define PNFC_T_ACC_CYC   ((`PNFC_T_ACC_NS + `PNFC_CLK_NS - 1) / `PNFC_CLK_NS)
`define PNFC_T_PACC_CYC  ((`PNFC_T_PACC_NS + `PNFC_CLK_NS - 1) / `PNFC_CLK_NS)
`define PNFC_T_WP_CYC    ((`PNFC_T_WP_NS + `PNFC_CLK_NS - 1) / `PNFC_CLK_NS)
`define PNFC_PAGE_WORDS  8
`endif

//--- core/pnfc_buscyc.v
// Purpose: One flash bus cycle (read or write) on the asynchronous pins
// Assumes: Flash pins timed from REF_CLK, inputs synchronous
// Notes:   Holds strobes for the given count of cycles plus one
`timescale 1ns/1ps
`default_nettype none
`include "pnfc_map.vh"
module pnfc_buscyc (
  input  wire        clk,
  input  wire        nrst,
  input  wire        start,
  input  wire        wr,
  input  wire [22:0] addr,
  input  wire [15:0] wdata,
  input  wire [2:0]  len,
  input  wire [15:0] dq_in,
  output reg  [22:0] a_out,
  output reg  [15:0] dq_out,
  output reg         dq_oe,
  output reg         ce_n,
  output reg         oe_n,
  output reg         we_n,
  output reg  [15:0] rdata,
  output reg         done
);
  reg [2:0] cnt;
  reg       act;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      a_out  <= 23'h000000;
      dq_out <= 16'h0000;
      dq_oe  <= 1'b0;
      ce_n   <= 1'b1;
      oe_n   <= 1'b1;
      we_n   <= 1'b1;
      rdata  <= 16'h0000;
      done   <= 1'b0;
      cnt    <= 3'h0;
      act    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !act) begin
        act    <= 1'b1;
        cnt    <= len;
        a_out  <= addr;
        dq_out <= wdata;
        dq_oe  <= wr;
        ce_n   <= 1'b0;
        oe_n   <= wr;
        we_n   <= !wr;
      end else if (act) begin
        if (cnt != 3'h0) begin
          cnt <= cnt - 3'h1;
        end else begin
          // Data sampled at the end, strobes released together
          if (!oe_n) begin
            rdata <= dq_in;
          end
          act   <= 1'b0;
          ce_n  <= 1'b1;
          oe_n  <= 1'b1;
          we_n  <= 1'b1;
          dq_oe <= 1'b0;
          done  <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/pnfc_top_sva.sv
// Purpose: Port checks on the flash controller
// Assumes: One clock, NRST async active low
// Notes:   Bound into pnfc_top after the module
`timescale 1ns/1ps
`default_nettype none
module pnfc_chk (
  input wire logic        REF_CLK,
  input wire logic        NRST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [22:0] FL_ADDR,
  input wire logic [15:0] FL_DQ_OUT,
  input wire logic        FL_DQ_OE,
  input wire logic        FL_CE_N,
  input wire logic        FL_OE_N,
  input wire logic        FL_WE_N,
  input wire logic        WRITE_PROTECT_ACCEL_IN
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  // ==========
  // Checks
  chk_ready_access: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("ready missing");
  chk_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready too long");
  chk_err_map:
    assert property (PSEL && PENABLE && PREADY |-> PSLVERR == (PADDR[1:0] != 2'h0
      || PADDR > 12'h014 || (PWRITE && PADDR == 12'h00c)))
    else $error("slave error wrong");
  chk_strobe_pair:
    assert property (!(FL_OE_N && FL_WE_N) |-> !FL_CE_N && FL_OE_N != FL_WE_N)
    else $error("strobe clash");
  chk_we_width:
    assert property ($fell(FL_WE_N) |-> !FL_WE_N [*3] ##1 FL_WE_N)
    else $error("write strobe width");
  chk_wr_hold:
    assert property (!FL_WE_N ##1 !FL_WE_N |-> $stable(FL_ADDR) && $stable(FL_DQ_OUT) && FL_DQ_OE)
    else $error("write cycle unstable");
  chk_rd_float: assert property (!FL_OE_N |-> !FL_DQ_OE)
    else $error("bus driven in read");
  chk_wp_follow:
    assert property (PSEL && PENABLE && PREADY && PWRITE && PADDR == 12'h014
      |-> ##2 WRITE_PROTECT_ACCEL_IN == !$past(PWDATA[0], 2))
    else $error("protect pin wrong");
endmodule
bind pnfc_top pnfc_chk chk (.REF_CLK, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
  .PREADY, .PSLVERR, .FL_ADDR, .FL_DQ_OUT, .FL_DQ_OE, .FL_CE_N, .FL_OE_N, .FL_WE_N,
  .WRITE_PROTECT_ACCEL_IN);
`default_nettype wire

//--- tb/pnfc_flash_model.sv
// Purpose: Behavioural word-wide NOR flash
// Assumes: No clock; strobe and address edges plus a 1 ns read poll
// Notes:   Released bus shows a changing pattern
`timescale 1ns/1ps
`default_nettype none
module pnfc_flash_model (
  input  wire logic [22:0] a,
  input  wire logic [15:0] dw,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        rst_n,
  input  wire logic        wp,
  output var  logic [15:0] dq,
  output wire logic        ry_n
);
  logic [15:0] mem[int];
  logic [15:0] pd;
  logic [19:0] pg;
  int          busy_len = 3;
  int          busy;
  int          st;
  bit          tg, pgm, e80, byp, xb, hit, sus, slp;
  logic [22:0] ba;
  realtime     t_a;
  initial dq = 16'h0000;
  assign ry_n = rst_n && busy == 0;
  function automatic logic [15:0] arr(input int k);
    return mem.exists(k) ? mem[k] : 16'hffff;
  endfunction
  function automatic bit prot(input logic [22:0] k);
    return !wp && (k < 23'h002000 || k >= 23'h7fe000);
  endfunction
  function automatic int sec(input int k);
    return (k < 'h8000 || k >= 'h7f8000) ? k >> 12 : (k >> 15) << 3;
  endfunction
  task automatic wcyc(input logic [22:0] k, input logic [15:0] d);
    int q[$];
    if (busy > 0 && (d == 16'h00b0 || d == 16'h0030)) sus = d == 16'h00b0;
    else if (busy > 0 || d == 16'h00f0) st = 0;
    else if (pgm) begin
      pgm = 0;
      if (!prot(k)) mem[k] = arr(k) & d;
      pd = d;
      ba = k;
      busy = busy_len;
    end else if (byp && xb) begin
      byp = 0;
      xb = 0;
    end else if (byp) begin
      pgm = d == 16'h00a0;
      xb = d == 16'h0090;
    end else if (st < 2)
      st = (k == (st ? 23'h2aa : 23'h555) && d == (st ? 16'h0055 : 16'h00aa)) ? st + 1 : 0;
    else begin
      st = 0;
      if (e80 && d == 16'h0030) begin
        e80 = 0;
        foreach (mem[j]) if (sec(j) == sec(k) && !prot(k)) q.push_back(j);
        foreach (q[i]) mem.delete(q[i]);
        pd = 16'hffff;
        ba = k;
        busy = busy_len;
      end else if (k == 23'h000555) begin
        pgm = d == 16'h00a0;
        e80 = d == 16'h0080;
        byp = d == 16'h0020;
      end
    end
  endtask
  always @(negedge rst_n) begin
    busy = 0;
    st = 0;
    {pgm, e80, byp, xb, sus} = 5'h00;
  end
  always @(negedge we_n) begin
    #10;
    // writes ignored while held in reset
    if (!ce_n && rst_n) wcyc(a, dw);
  end
  always @(posedge oe_n) if (busy > 0 && !sus) begin
    tg = !tg;
    busy--;
  end
  always @(a) begin
    hit = a[22:3] == pg;
    pg = a[22:3];
    t_a = $realtime;
  end
  // sleep after 300 ns of stable address
  // other banks read array while busy
  always #1 begin
    slp = $realtime - t_a >= 300;
    if (!ce_n && !oe_n && $realtime - t_a >= (hit ? 30 : 70))
      dq = (busy > 0 && !sus && a[22:21] == ba[22:21]) ? {8'h00, !pd[7], tg, 6'h00} : arr(a);
    else
      dq = ~dq;
  end
endmodule
`default_nettype wire

//--- tb/parallel_nor_flash_command_core_tb.sv
// Purpose: Self-checking bench for the flash controller
// Assumes: Flash model on the pins, APB from tasks
// Notes:   Reference array mirrors the flash contents
`timescale 1ns/1ps
`default_nettype none
`include "pnfc_map.vh"
module parallel_nor_flash_command_core_tb;
  logic        clk = 0;
  logic        nrst = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic        pready, pslverr, err, foe, ce_n, oe_n, we_n, frst_n, ry_n, wp;
  logic [22:0] fa, a0, a1;
  logic [15:0] fdo, fdi, dm, d;
  logic [15:0] rm[int];
  int          bad_count, checks, nwr, cyc, i;
  bit          byp;
  always #10 clk = ~clk;
  assign fdi = foe ? fdo : dm;
  always @(posedge we_n) nwr++;
  pnfc_top dut (.REF_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .FL_ADDR(fa), .FL_DQ_OUT(fdo), .FL_DQ_OE(foe), .FL_DQ_IN(fdi), .FL_CE_N(ce_n),
    .FL_OE_N(oe_n), .FL_WE_N(we_n), .FL_RESET_N(frst_n), .READY_BUSY_OUT_N(ry_n),
    .WRITE_PROTECT_ACCEL_IN(wp));
  pnfc_flash_model fm (.a(fa), .dw(fdo), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .rst_n(frst_n), .wp(wp), .dq(dm), .ry_n(ry_n));
  task automatic complete_run;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      complete_run;
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input bit w, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input logic [3:0] c, input logic [22:0] ad, input logic [15:0] wd);
    apb(1, `PNFC_OFS_ADDR, {9'h000, ad});
    apb(1, `PNFC_OFS_WDATA, {16'h0000, wd});
    nwr = 0;
    apb(1, `PNFC_OFS_CTRL, {28'h0000000, c});
    do apb(0, `PNFC_OFS_STATUS, 32'h0); while (rdat[0] !== 1'b0);
    apb(1, `PNFC_OFS_STATUS, 32'h0);
  endtask
  function automatic logic [15:0] rv(input int k);
    return rm.exists(k) ? rm[k] : 16'hffff;
  endfunction
  task automatic rdchk(input logic [22:0] ad);
    run(`PNFC_CMD_READ, ad, 16'h0000);
    apb(0, `PNFC_OFS_RDATA, 32'h0);
    chk("array word", rdat[15:0], rv(ad));
  endtask
  task automatic prog(input logic [22:0] ad, input logic [15:0] wd, input bit ok);
    fm.busy_len = $urandom_range(6, 1);
    run(`PNFC_CMD_PROG, ad, wd);
    chk("write cycles", nwr, byp ? 2 : 4);
    if (ok) rm[ad] = rv(ad) & wd;
    rdchk(ad);
  endtask
  initial begin
    void'($urandom(83147));
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    apb(0, `PNFC_OFS_STATUS, 32'h0);
    chk("idle status", rdat[6:0], 7'h10);
    chk("wp pin", wp, 1'b1);
    apb(0, 12'h018, 32'h0);
    chk("slave error", err, 1'b1);
    chk("flash reset", frst_n, 1'b1);
    for (i = 0; i < 5; i++) begin
      a0 = 23'($urandom_range(32'h7f7fff, 32'h8000));
      if (i == 0) a1 = a0;
      d = 16'($urandom);
      prog(a0, d, 1'b1);
      d = 16'($urandom);
      prog(a0, d, 1'b1);
      prog(a0 ^ 23'h1, d, 1'b1);
      rdchk(a0);
    end
    fm.busy_len = 9;
    run(`PNFC_CMD_ERASE, a0, 16'h0000);
    chk("erase cycles", nwr, 6);
    foreach (rm[k]) if (k >> 15 == a0 >> 15) rm[k] = 16'hffff;
    rdchk(a0);
    rdchk(a1);
    run(`PNFC_CMD_BYP_IN, a1, 16'h0000);
    chk("bypass entry", nwr, 3);
    apb(0, `PNFC_OFS_STATUS, 32'h0);
    chk("bypass flag", rdat[3], 1'b1);
    byp = 1;
    prog(a1 + 23'h40, 16'($urandom), 1'b1);
    run(`PNFC_CMD_BYP_OUT, a1, 16'h0000);
    byp = 0;
    chk("bypass exit", nwr, 2);
    apb(1, `PNFC_OFS_PROT, 32'h1);
    repeat (2) @(posedge clk);
    chk("wp pin", wp, 1'b0);
    prog(23'h000010, 16'h0000, 1'b0);
    prog(23'h7fff00, 16'h0000, 1'b0);
    apb(1, `PNFC_OFS_PROT, 32'h0);
    prog(23'h000010, 16'h1234, 1'b1);
    for (i = 6; i < 11; i++) begin
      run(4'(i), a1, 16'h0000);
      chk("single write", nwr, 1);
    end
    for (i = 0; i < 3; i++) begin
      a0 = (i == 1) ? 23'h0002aa : 23'h000555;
      d = (i == 0) ? 16'h00aa : (i == 1) ? 16'h0055 : 16'h0011;
      run(4'hd, a0, d);
      chk("raw write", nwr, 1);
      chk("raw address", fa, a0);
    end
    rdchk(a1);
    run(`PNFC_CMD_STBY, a1, 16'h0000);
    apb(0, `PNFC_OFS_STATUS, 32'h0);
    chk("standby flag", rdat[5], 1'b1);
    run(`PNFC_CMD_WAKE, a1, 16'h0000);
    apb(0, `PNFC_OFS_STATUS, 32'h0);
    chk("standby flag", rdat[5], 1'b0);
    chk("auto sleep", fm.slp, 1'b1);
    complete_run;
  end
endmodule
`default_nettype wire
